// ### rtl/mis_pkg.sv
// Constants and types for the interrupt sequencer of an 8-bit core.
// Assumes a 32-bit classic Wishbone register bus, word aligned.
package mis_pkg;

    // Register byte offsets
    localparam logic [7:0] MIS_OFS_CTRL     = 8'h00;
    localparam logic [7:0] MIS_OFS_SENSE    = 8'h04;
    localparam logic [7:0] MIS_OFS_ENABLE   = 8'h08;
    localparam logic [7:0] MIS_OFS_STATUS   = 8'h0C;
    localparam logic [7:0] MIS_OFS_ASSOC    = 8'h10;
    localparam logic [7:0] MIS_OFS_SUPPLY   = 8'h14;
    localparam logic [7:0] MIS_OFS_PIN_EN   = 8'h18;
    localparam logic [7:0] MIS_OFS_ACTIVE   = 8'h1C;

    // Source counts and indices (index 0 has highest priority)
    localparam int         MIS_NUM_EXT      = 2;
    localparam int         MIS_NUM_PERIPH   = 4;
    localparam int         MIS_NUM_SRC      = 7;
    localparam logic [2:0] MIS_SRC_PERIPH0  = 3'h2;
    localparam logic [2:0] MIS_SRC_SUPPLY   = 3'h6;
    localparam int         MIS_GROUP_PINS   = 4;

    // Sources allowed to end halt mode: the external lines only
    localparam logic [6:0] MIS_HALT_WAKE    = 7'h03;

    // Sensitivity codes per external source
    localparam logic [1:0] MIS_SENSE_FALL_LOW = 2'h0;
    localparam logic [1:0] MIS_SENSE_RISE     = 2'h1;
    localparam logic [1:0] MIS_SENSE_FALL     = 2'h2;
    localparam logic [1:0] MIS_SENSE_BOTH     = 2'h3;

    // Supply status register fields
    localparam int         MIS_SUP_FLAG_BIT = 0;
    localparam int         MIS_SUP_EN_BIT   = 1;

    // Vectors
    localparam logic [15:0] MIS_VEC_TRAP    = 16'hFFFC;
    localparam logic [15:0] MIS_VEC_TOP     = 16'hFFFA;
    localparam logic [15:0] MIS_VEC_STEP    = 16'h0002;

    // Stack slots, pushed in this order and popped in reverse
    localparam logic [1:0] MIS_SLOT_PC      = 2'h0;
    localparam logic [1:0] MIS_SLOT_CC      = 2'h3;

    // Reset values
    localparam logic       MIS_MASK_RST     = 1'b1;
    localparam logic [1:0] MIS_LINE_IDLE    = 2'h3;

    typedef enum logic [2:0] {
        MIS_RUN,
        MIS_PUSH,
        MIS_LOAD,
        MIS_POP,
        MIS_WAIT,
        MIS_HALT
    } mis_state_t;

endpackage : mis_pkg

// ### rtl/mis_edge_latch.sv
// One external request line: sensitivity decode and request latch.
// Assumes the line is synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module mis_edge_latch
    import mis_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Line and configuration
    input  wire logic       line_i,
    input  wire logic [1:0] sense_i,
    input  wire logic       clr_i,
    // Request
    output logic            req_o
);

    typedef struct packed {
        logic prev;
        logic latched;
    } mis_edge_t;

    mis_edge_t r;
    mis_edge_t next_r;
    logic      rise;
    logic      fall;
    logic      hit;

    always_comb begin
        next_r = r;
        rise   = line_i & ~r.prev;
        fall   = ~line_i & r.prev;
        case (sense_i)
            MIS_SENSE_RISE: hit = rise;
            MIS_SENSE_BOTH: hit = rise | fall;
            default:        hit = fall;
        endcase
        next_r.prev = line_i;
        // Edge latched; entry clears it but a new edge wins [R12]
        if (hit) begin
            next_r.latched = 1'b1;
        end else if (clr_i) begin
            next_r.latched = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r.prev    <= MIS_LINE_IDLE[0];
            r.latched <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // Falling/low mode also requests while the line stays low
    assign req_o = r.latched | ((sense_i == MIS_SENSE_FALL_LOW) & ~r.prev);

endmodule : mis_edge_latch
`default_nettype wire

// ### rtl/mis_sequencer.sv
// Interrupt sequencer: request latching, masking, priority, entry and
// return sequences, wait/halt wake-up, supply-level monitor interrupt.
// Assumes the core pulses the opcode inputs with instr_boundary_i and
// stalls while core_hold_o is high; registers on classic Wishbone.
//
// Notes on behaviour
// R1 - Maskable requests serviced only while mask flag clear; masked ones stay latched.
// R2 - After reset every source is disabled until software enables it.
// R3 - Entry starts only at the end of the current instruction.
// R4 - Entry pushes program counter, index, accumulator and condition codes.
// R5 - Entry sets the global mask flag.
// R6 - After the save the vector of the chosen source is loaded.
// R7 - Handler return pops the saved registers and clears the mask flag.
// R8 - Fixed priority picks among simultaneous pending requests.
// R9 - Any source wakes from wait; only external and designated ones from halt.
// R10 - Software exception starts entry whatever the mask flag.
// R11 - Each external source has a configurable sensitivity field.
// R12 - Edge requests latch and clear automatically on handler entry.
// R13 - Low level on any enabled grouped pin blocks the combined request.
// R14 - Peripheral flag interrupts only when unmasked and enabled, else stays pending.
// R15 - Software clears by writing 0 or status access then associated access.
// R16 - A finished clear sequence discards the pending request.
// R17 - Supply event interrupts only when enabled and unmasked.
// R18 - In wait the supply monitor runs and its interrupt ends wait.
// R19 - In halt the supply status freezes and cannot end halt.
// R20 - Entering wait clears the mask flag.
// R21 - Entering halt clears the mask flag, so pending requests wake at once; only enabled external-line requests wake halt here.
// R22 - After return, still-latched requests are arbitrated at the next boundary.
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module mis_sequencer
    import mis_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Core instruction events, valid with instr_boundary_i
    input  wire logic        instr_boundary_i,
    input  wire logic        trap_opcode_i,
    input  wire logic        return_from_handler_i,
    input  wire logic        mask_opcode_i,
    input  wire logic        unmask_opcode_i,
    input  wire logic        wait_entry_opcode_i,
    input  wire logic        halt_opcode_i,
    // Core control
    output logic             core_hold_o,
    output logic             stack_push_o,
    output logic             stack_pop_o,
    output logic [1:0]       stack_sel_o,
    output logic             vector_load_o,
    output logic [15:0]      program_counter_o,
    output logic             condition_mask_o,
    output logic             wait_mode_o,
    output logic             halt_mode_o,
    // Interrupt sources
    input  wire logic [3:0]  group_pins_i,
    input  wire logic        external_request_line_i,
    input  wire logic [3:0]  periph_event_i,
    input  wire logic        supply_level_event_i
);

    typedef struct packed {
        mis_state_t  state;
        logic [1:0]  cnt;
        logic [2:0]  src;
        logic        is_trap;
        logic        mask;
        logic [3:0]  sense;
        logic [3:0]  pin_en;
        logic [5:0]  enable;
        logic [3:0]  pflag;
        logic [3:0]  armed;
        logic        sup_flag;
        logic        sup_en;
        logic        ack;
        logic [31:0] rdata;
        logic        push;
        logic        pop;
        logic [1:0]  sel;
        logic        vload;
        logic [15:0] vector;
    } mis_regs_t;

    mis_regs_t r;
    mis_regs_t next_r;

    logic [1:0] ext_line;
    logic [1:0] ext_req;
    logic [1:0] ext_clr;
    logic [6:0] pending;
    logic [6:0] active;
    logic [6:0] halt_active;
    logic [2:0] win;
    logic [2:0] halt_win;
    logic       bus_req;
    logic       wr_hit;
    logic       rd_hit;

    // Grouped pins: any enabled pin held low keeps the combined line low [R13]
    assign ext_line[0] = &(group_pins_i | ~r.pin_en);
    assign ext_line[1] = external_request_line_i;

    // Per-line sensitivity and edge latch [R11]
    genvar gi;
    generate
        for (gi = 0; gi < MIS_NUM_EXT; gi++) begin : g_ext
            mis_edge_latch u_edge (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .line_i  (ext_line[gi]),
                .sense_i (r.sense[2*gi +: 2]),
                .clr_i   (ext_clr[gi]),
                .req_o   (ext_req[gi])
            );
        end
    endgenerate

    // Lowest index wins
    function automatic logic [2:0] mis_pick(input logic [6:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = MIS_NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : mis_pick

    always_comb begin
        // Pending requests gated by per-source enables [R14] [R17]
        pending     = {r.sup_flag, r.pflag, ext_req};
        active      = pending & {r.sup_en, r.enable};
        halt_active = active & MIS_HALT_WAKE;
        win         = mis_pick(active);                       // [R8]
        halt_win    = mis_pick(halt_active);
        bus_req     = wb_cyc_i & wb_stb_i;
        wr_hit      = bus_req & wb_we_i & r.ack & wb_sel_i[0];
        rd_hit      = bus_req & ~wb_we_i & r.ack;
    end

    always_comb begin
        next_r       = r;
        ext_clr      = 2'h0;
        next_r.push  = 1'b0;
        next_r.pop   = 1'b0;
        next_r.vload = 1'b0;

        // Bus slave: one wait state, ack drops after one cycle
        next_r.ack = bus_req & ~r.ack;
        case (wb_adr_i)
            MIS_OFS_CTRL:   next_r.rdata = {31'h0, r.mask};
            MIS_OFS_SENSE:  next_r.rdata = {28'h0, r.sense};
            MIS_OFS_ENABLE: next_r.rdata = {26'h0, r.enable};
            MIS_OFS_STATUS: next_r.rdata = {28'h0, r.pflag};
            MIS_OFS_SUPPLY: next_r.rdata = {30'h0, r.sup_en, r.sup_flag};
            MIS_OFS_PIN_EN: next_r.rdata = {28'h0, r.pin_en};
            MIS_OFS_ACTIVE: next_r.rdata = {25'h0, active};
            default:        next_r.rdata = 32'h0000_0000;
        endcase

        if (wr_hit) begin
            case (wb_adr_i)
                MIS_OFS_SENSE:  next_r.sense  = wb_dat_i[3:0];
                MIS_OFS_ENABLE: next_r.enable = wb_dat_i[5:0];
                MIS_OFS_PIN_EN: next_r.pin_en = wb_dat_i[3:0];
                // Writing 0 clears a flag; writing 1 leaves it [R15]
                MIS_OFS_STATUS: next_r.pflag  = r.pflag & wb_dat_i[3:0];
                MIS_OFS_SUPPLY: begin
                    // Supply status frozen while halted [R19]
                    if (r.state != MIS_HALT) begin
                        next_r.sup_flag = r.sup_flag & wb_dat_i[MIS_SUP_FLAG_BIT];
                        next_r.sup_en   = wb_dat_i[MIS_SUP_EN_BIT];
                    end
                end
                default: ;
            endcase
        end

        // Clear sequence: status access arms set flags, associated access clears
        if (r.ack && bus_req) begin
            if (wb_adr_i == MIS_OFS_STATUS) begin
                next_r.armed = r.pflag;                        // [R15]
            end else if (wb_adr_i == MIS_OFS_ASSOC) begin
                next_r.pflag = next_r.pflag & ~r.armed;        // [R16]
                next_r.armed = 4'h0;
            end
        end

        // New events win over any clear in the same cycle
        next_r.pflag = next_r.pflag | periph_event_i;
        // Monitor keeps running in wait, inactive in halt [R18] [R19]
        if (supply_level_event_i && r.state != MIS_HALT) begin
            next_r.sup_flag = 1'b1;
        end

        case (r.state)
            MIS_RUN: begin
                if (instr_boundary_i) begin                  // [R3]
                    if (trap_opcode_i) begin
                        // Unconditional entry [R10]
                        next_r.is_trap = 1'b1;
                        next_r.mask    = 1'b1;
                        next_r.cnt     = 2'h0;
                        next_r.state   = MIS_PUSH;
                    end else if (return_from_handler_i) begin
                        next_r.cnt   = 2'h0;
                        next_r.state = MIS_POP;
                    end else if (wait_entry_opcode_i) begin
                        next_r.mask  = 1'b0;                   // [R20]
                        next_r.state = MIS_WAIT;
                    end else if (halt_opcode_i) begin
                        next_r.mask  = 1'b0;                   // [R21]
                        next_r.state = MIS_HALT;
                    end else if (mask_opcode_i) begin
                        next_r.mask = 1'b1;
                    end else if (unmask_opcode_i) begin
                        next_r.mask = 1'b0;
                    end else if (!r.mask && active != 7'h00) begin
                        // Serviced only when unmasked [R1] [R14] [R17] [R22]
                        next_r.is_trap = 1'b0;
                        next_r.src     = win;
                        next_r.mask    = 1'b1;                 // [R5]
                        next_r.cnt     = 2'h0;
                        next_r.state   = MIS_PUSH;
                        if (win < 3'(MIS_NUM_EXT)) begin
                            ext_clr[win[0]] = 1'b1;            // [R12]
                        end
                    end
                end
            end
            MIS_WAIT: begin
                // Any enabled source ends wait [R9] [R18]
                if (active != 7'h00) begin
                    next_r.is_trap = 1'b0;
                    next_r.src     = win;
                    next_r.mask    = 1'b1;                     // [R5]
                    next_r.cnt     = 2'h0;
                    next_r.state   = MIS_PUSH;
                    if (win < 3'(MIS_NUM_EXT)) begin
                        ext_clr[win[0]] = 1'b1;                // [R12]
                    end
                end
            end
            MIS_HALT: begin
                // Only external lines end halt [R9] [R19] [R21]
                if (halt_active != 7'h00) begin
                    next_r.is_trap  = 1'b0;
                    next_r.src      = halt_win;
                    next_r.mask     = 1'b1;                    // [R5]
                    next_r.cnt      = 2'h0;
                    next_r.state    = MIS_PUSH;
                    ext_clr[halt_win[0]] = 1'b1;               // [R12]
                end
            end
            MIS_PUSH: begin
                // Program counter, index, accumulator, condition codes [R4]
                next_r.push = 1'b1;
                next_r.sel  = MIS_SLOT_PC + r.cnt;
                next_r.cnt  = r.cnt + 2'h1;
                if (r.cnt == MIS_SLOT_CC) begin
                    next_r.state = MIS_LOAD;
                end
            end
            MIS_LOAD: begin
                // Vector of the chosen source [R6]
                next_r.vload  = 1'b1;
                next_r.vector = r.is_trap ? MIS_VEC_TRAP
                              : MIS_VEC_TOP - (MIS_VEC_STEP * {13'h0, r.src});
                next_r.state  = MIS_RUN;
            end
            MIS_POP: begin
                // Restore in reverse order, then unmask [R7]
                next_r.pop = 1'b1;
                next_r.sel = MIS_SLOT_CC - r.cnt;
                next_r.cnt = r.cnt + 2'h1;
                if (r.cnt == MIS_SLOT_CC) begin
                    next_r.mask  = 1'b0;                       // [R7] [R22]
                    next_r.state = MIS_RUN;
                end
            end
            default: next_r.state = MIS_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r.state    <= MIS_RUN;
            r.cnt      <= 2'h0;
            r.src      <= 3'h0;
            r.is_trap  <= 1'b0;
            r.mask     <= MIS_MASK_RST;
            r.sense    <= 4'h0;
            r.pin_en   <= 4'h0;
            r.enable   <= 6'h00;                               // [R2]
            r.pflag    <= 4'h0;
            r.armed    <= 4'h0;
            r.sup_flag <= 1'b0;
            r.sup_en   <= 1'b0;                                // [R2]
            r.ack      <= 1'b0;
            r.rdata    <= 32'h0000_0000;
            r.push     <= 1'b0;
            r.pop      <= 1'b0;
            r.sel      <= 2'h0;
            r.vload    <= 1'b0;
            r.vector   <= 16'h0000;
        end else begin
            r <= next_r;
        end
    end

    assign wb_ack_o          = r.ack;
    assign wb_dat_o          = r.rdata;
    assign core_hold_o       = (r.state != MIS_RUN) | r.vload;
    assign stack_push_o      = r.push;
    assign stack_pop_o       = r.pop;
    assign stack_sel_o       = r.sel;
    assign vector_load_o     = r.vload;
    assign program_counter_o = r.vector;
    assign condition_mask_o  = r.mask;
    assign wait_mode_o       = (r.state == MIS_WAIT);
    assign halt_mode_o       = (r.state == MIS_HALT);

endmodule : mis_sequencer
`default_nettype wire

// ### testbench/mis_seq_chk.sv
// Port checker for the sequencer.
// Assumes binding to each sequencer.
`timescale 1ns/1ps
`default_nettype none
module mis_seq_chk
    import mis_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        instr_boundary_i,
    input  wire logic        trap_opcode_i,
    input  wire logic        return_from_handler_i,
    input  wire logic        wait_entry_opcode_i,
    input  wire logic        halt_opcode_i,
    input  wire logic        core_hold_o,
    input  wire logic        stack_push_o,
    input  wire logic        stack_pop_o,
    input  wire logic [1:0]  stack_sel_o,
    input  wire logic        vector_load_o,
    input  wire logic [15:0] program_counter_o,
    input  wire logic        condition_mask_o,
    input  wire logic        wait_mode_o,
    input  wire logic        halt_mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire taken = instr_boundary_i && !core_hold_o;
    wire plain = taken && condition_mask_o && !trap_opcode_i && !return_from_handler_i;

    chk_push_order: assert property (
        stack_push_o && stack_sel_o == 2'h0 |=> stack_push_o && stack_sel_o == 2'h1
        ##1 stack_push_o && stack_sel_o == 2'h2 ##1 stack_push_o && stack_sel_o == 2'h3
        ##1 vector_load_o && !stack_push_o)
        else $error("push order");
    chk_entry_mask: assert property (
        stack_push_o && stack_sel_o == 2'h0 |-> condition_mask_o && core_hold_o)
        else $error("unmasked push");
    chk_entry_boundary: assert property (
        $rose(stack_push_o) && !$past(wait_mode_o, 2) && !$past(halt_mode_o, 2)
        |-> $past(instr_boundary_i, 2))
        else $error("entry off boundary");
    chk_pop_order: assert property (
        stack_pop_o && stack_sel_o == 2'h3 |=> stack_pop_o && stack_sel_o == 2'h2
        ##1 stack_pop_o && stack_sel_o == 2'h1
        ##1 stack_pop_o && stack_sel_o == 2'h0 && !condition_mask_o)
        else $error("pop order");
    chk_masked_hold: assert property (
        taken && condition_mask_o && !trap_opcode_i |=> ##1 !stack_push_o)
        else $error("entry while masked");
    chk_trap_entry: assert property (
        taken && trap_opcode_i |=> ##1 stack_push_o && stack_sel_o == 2'h0
        ##4 vector_load_o && program_counter_o == MIS_VEC_TRAP)
        else $error("trap not entered");
    chk_wait_unmask: assert property (
        plain && wait_entry_opcode_i |=> wait_mode_o && !condition_mask_o)
        else $error("wait kept mask");
    chk_halt_unmask: assert property (
        plain && halt_opcode_i && !wait_entry_opcode_i |=> halt_mode_o && !condition_mask_o)
        else $error("halt kept mask");
    chk_hold_release: assert property (
        vector_load_o |-> core_hold_o ##1 !core_hold_o)
        else $error("hold not released");
endmodule : mis_seq_chk
bind mis_sequencer mis_seq_chk i_mis_seq_chk (.*);
`default_nettype wire

// ### testbench/mis_core_model.sv
// Core model: paces boundaries, issues opcodes.
// Assumes core_hold_i stalls it.
`timescale 1ns/1ps
`default_nettype none
module mis_core_model #(
    parameter int PACE = 2
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       core_hold_i,
    input  wire logic [5:0] op_i,
    output logic            instr_boundary_o,
    output logic [5:0]      op_o,
    output logic            op_taken_o
);
    logic [3:0] pace_cnt;
    // No instruction completes while stalled
    assign instr_boundary_o = !core_hold_i && !rst_i && pace_cnt == 4'h0;
    assign op_o             = instr_boundary_o ? op_i : 6'h00;
    assign op_taken_o       = instr_boundary_o && op_i != 6'h00;
    always_ff @(posedge clk_i) begin
        if (rst_i || pace_cnt == 4'h0) begin
            pace_cnt <= 4'(PACE - 1);
        end else begin
            pace_cnt <= pace_cnt - 4'h1;
        end
    end
endmodule : mis_core_model
`default_nettype wire

// ### testbench/mis_sequencer_tb.sv
// Bench: register bus, core opcodes, interrupt sources.
// Assumes the bound checker and the core model.
`timescale 1ns/1ps
`default_nettype none
module mis_sequencer_tb
    import mis_pkg::*;
;
    localparam logic [5:0] OP_TRAP = 6'h01, OP_RET = 6'h02, OP_MASK = 6'h04;
    localparam logic [5:0] OP_UNM = 6'h08, OP_WAIT = 6'h10, OP_HALT = 6'h20;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
    logic        boundary, hold, vload, mask, wmode, hmode, op_taken;
    logic [15:0] pc;
    logic [5:0]  op_req = 6'h00, op;
    logic [3:0]  group_pins_i = 4'hF, periph_ev = 4'h0;
    logic        ext_line = 1'b1, supply_ev = 1'b0;
    int          n_mismatch = 0, checks_done = 0, n_entry = 0, cycles = 0, seen, base;

    mis_sequencer i_mis_sequencer (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .instr_boundary_i(boundary),
        .trap_opcode_i(op[0]), .return_from_handler_i(op[1]), .mask_opcode_i(op[2]),
        .unmask_opcode_i(op[3]), .wait_entry_opcode_i(op[4]), .halt_opcode_i(op[5]),
        .core_hold_o(hold), .stack_push_o(), .stack_pop_o(), .stack_sel_o(),
        .vector_load_o(vload), .program_counter_o(pc), .condition_mask_o(mask),
        .wait_mode_o(wmode), .halt_mode_o(hmode), .group_pins_i(group_pins_i),
        .external_request_line_i(ext_line), .periph_event_i(periph_ev),
        .supply_level_event_i(supply_ev));
    mis_core_model i_mis_core_model (
        .clk_i(clk_i), .rst_i(rst_i), .core_hold_i(hold), .op_i(op_req),
        .instr_boundary_o(boundary), .op_o(op), .op_taken_o(op_taken));

    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (vload === 1'b1) n_entry <= n_entry + 1;
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic check(input string name, input logic [31:0] seen_v, input logic [31:0] exp);
        checks_done++;
        if (seen_v !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen_v);
        end
    endtask : check
    task automatic acc(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : acc
    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
        acc(1'b0, adr, 32'h0000_0000);
        check("reg", rd, exp);
    endtask : rdc
    task automatic do_op(input logic [5:0] code);
        @(posedge clk_i);
        op_req <= code;
        do @(posedge clk_i); while (op_taken !== 1'b1);
        op_req <= 6'h00;
    endtask : do_op
    task automatic pulse(input logic [3:0] p, input logic s);
        @(posedge clk_i);
        periph_ev <= p;
        supply_ev <= s;
        @(posedge clk_i);
        periph_ev <= 4'h0;
        supply_ev <= 1'b0;
    endtask : pulse
    task automatic no_entry();
        base = n_entry;
        repeat (20) @(posedge clk_i);
        check("entries", n_entry, base);
    endtask : no_entry
    task automatic expect_entry(input logic [15:0] vec);
        for (int i = 0; i < 60 && vload !== 1'b1; i++) @(posedge clk_i);
        check("vector", {16'h0000, pc}, {16'h0000, vec});
    endtask : expect_entry
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 9; i++) rdc(8'(4 * i), (i == 0) ? 32'h1 : 32'h0);
        acc(1'b1, MIS_OFS_PIN_EN, 32'h0000_000F);
        acc(1'b1, MIS_OFS_SENSE, 32'h0000_0001);
        // Disabled peripheral request stays pending
        pulse(4'h1, 1'b0);
        rdc(MIS_OFS_STATUS, 32'h1);
        rdc(MIS_OFS_ACTIVE, 32'h0);
        do_op(OP_UNM);
        no_entry();
        acc(1'b1, MIS_OFS_ENABLE, 32'h0000_002C);
        expect_entry(16'hFFF6);
        rdc(MIS_OFS_CTRL, 32'h1);
        // Requests raised inside a handler wait for the return
        pulse(4'hA, 1'b0);
        no_entry();
        acc(1'b1, MIS_OFS_STATUS, 32'h0000_000E);
        do_op(OP_RET);
        expect_entry(16'hFFF4);
        acc(1'b1, MIS_OFS_ENABLE, 32'h0000_000C);
        acc(1'b0, MIS_OFS_STATUS, 32'h0000_0000);
        acc(1'b0, MIS_OFS_ASSOC, 32'h0000_0000);
        rdc(MIS_OFS_STATUS, 32'h0);
        acc(1'b1, MIS_OFS_ENABLE, 32'h0000_002C);
        do_op(OP_RET);
        no_entry();
        do_op(OP_MASK);
        do_op(OP_TRAP);
        expect_entry(MIS_VEC_TRAP);
        do_op(OP_RET);
        // Grouped pins: one low pin blocks the combined line
        acc(1'b1, MIS_OFS_ENABLE, 32'h0000_0001);
        @(posedge clk_i) group_pins_i <= 4'hE;
        @(posedge clk_i) group_pins_i <= 4'hC;
        @(posedge clk_i) group_pins_i <= 4'hE;
        no_entry();
        @(posedge clk_i) group_pins_i <= 4'hF;
        expect_entry(16'hFFFA);
        rdc(MIS_OFS_ACTIVE, 32'h0);
        do_op(OP_RET);
        no_entry();
        acc(1'b1, MIS_OFS_ENABLE, 32'h0000_0002);
        for (int code = 0; code < 4; code++) begin
            acc(1'b1, MIS_OFS_SENSE, 32'(code * 4 + 1));
            base = n_entry;
            seen = n_entry;
            @(posedge clk_i) ext_line <= 1'b0;
            repeat (20) @(posedge clk_i);
            ext_line <= 1'b1;
            repeat (20) @(posedge clk_i);
            for (int k = 0; k < 3; k++) begin
                if (n_entry > seen) begin
                    seen = n_entry;
                    do_op(OP_RET);
                    repeat (20) @(posedge clk_i);
                end
            end
            check("sense", n_entry - base, (code == 3) ? 2 : 1);
        end
        // Supply monitor wakes from wait
        do_op(OP_MASK);
        acc(1'b1, MIS_OFS_SUPPLY, 32'h0000_0002);
        do_op(OP_WAIT);
        rdc(MIS_OFS_CTRL, 32'h0);
        check("wait", wmode, 1'b1);
        pulse(4'h0, 1'b1);
        expect_entry(16'hFFEE);
        acc(1'b1, MIS_OFS_SUPPLY, 32'h0000_0002);
        do_op(OP_RET);
        // Halt ignores the supply monitor, ext0 wakes it
        acc(1'b1, MIS_OFS_ENABLE, 32'h0000_0001);
        do_op(OP_MASK);
        do_op(OP_HALT);
        rdc(MIS_OFS_CTRL, 32'h0);
        pulse(4'h0, 1'b1);
        no_entry();
        check("halt", hmode, 1'b1);
        rdc(MIS_OFS_SUPPLY, 32'h2);
        @(posedge clk_i) group_pins_i <= 4'hE;
        @(posedge clk_i) group_pins_i <= 4'hF;
        expect_entry(16'hFFFA);
        do_op(OP_RET);
        test_done();
    end
endmodule : mis_sequencer_tb
`default_nettype wire
